// >>> shared/acc_pkg.sv
// constants and types shared by the accumulator core decode/execute logic
`default_nettype none
package acc_pkg;
  localparam int ACC_DW = 8;
  localparam int ACC_PW = 12;
  localparam int ACC_SP_DEPTH = 6;
  // cycle counts per group
  localparam logic [2:0] CYC_ALU = 3'h4;
  localparam logic [2:0] CYC_REL = 3'h2;
  localparam logic [2:0] CYC_BTB = 3'h5;
  localparam logic [2:0] CYC_BIT = 3'h4;
  localparam logic [2:0] CYC_CTL = 3'h2;
  localparam logic [2:0] CYC_JMP = 3'h4;
  // instruction lengths
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [ACC_PW-1:0] PC_RESET = 12'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  // operations seen by the executer
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_AND = 5'h02, OP_CMP = 5'h03, OP_SUB = 5'h04,
    OP_CLRA = 5'h05, OP_CLRM = 5'h06, OP_COM = 5'h07, OP_RLC = 5'h08, OP_SLA = 5'h09,
    OP_INC = 5'h0A, OP_DEC = 5'h0B, OP_BRC = 5'h0C, OP_BRNC = 5'h0D, OP_BRZ = 5'h0E,
    OP_BRNZ = 5'h0F, OP_BTR = 5'h10, OP_BTS = 5'h11, OP_BSET = 5'h12, OP_BCLR = 5'h13,
    OP_RET = 5'h14, OP_INTERRUPT_RETURN = 5'h15, OP_STOP = 5'h16, OP_WAIT = 5'h17, OP_JP = 5'h18,
    OP_CALL = 5'h19, OP_ILL = 5'h1F
  } acc_op_type;
  // operand source for two-operand alu ops
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0, SRC_MEM = 2'h1, SRC_IMM = 2'h2
  } acc_src_type;
  // opcode values (group encodings chosen for this core)
  localparam logic [7:0] OPC_ADD_IX = 8'h47;
  localparam logic [7:0] OPC_ADD_IY = 8'h57;
  localparam logic [7:0] OPC_ADD_D = 8'h5F;
  localparam logic [7:0] OPC_ADD_IMMEDIATE = 8'h4F;
  localparam logic [7:0] OPC_AND_IX = 8'hA7;
  localparam logic [7:0] OPC_AND_IY = 8'hB7;
  localparam logic [7:0] OPC_AND_D = 8'hBF;
  localparam logic [7:0] OPC_AND_IMMEDIATE = 8'hAF;
  localparam logic [7:0] OPC_CP_IX = 8'h27;
  localparam logic [7:0] OPC_CP_IY = 8'h37;
  localparam logic [7:0] OPC_CP_D = 8'h3F;
  localparam logic [7:0] OPC_CPI = 8'h2F;
  localparam logic [7:0] OPC_SUB_IX = 8'hC7;
  localparam logic [7:0] OPC_SUB_IY = 8'hD7;
  localparam logic [7:0] OPC_SUB_D = 8'hDF;
  localparam logic [7:0] OPC_SUBTRACT_IMMEDIATE = 8'hCF;
  localparam logic [7:0] OPC_INC_D = 8'h7F;
  localparam logic [7:0] OPC_DEC_D = 8'hFF;
  localparam logic [7:0] OPC_INC_IX = 8'h67;
  localparam logic [7:0] OPC_DEC_IX = 8'hE7;
  localparam logic [7:0] OPC_CLRA = 8'hDD;
  localparam logic [7:0] OPC_CLRM = 8'h0D;
  localparam logic [7:0] OPC_COM = 8'h2D;
  localparam logic [7:0] OPC_RLC = 8'hAD;
  localparam logic [7:0] OPC_SLA = 8'h5D;
  localparam logic [7:0] OPC_NOP = 8'h04;
  localparam logic [7:0] OPC_RET = 8'hCD;
  localparam logic [7:0] OPC_INTERRUPT_RETURN = 8'h4D;
  localparam logic [7:0] OPC_STOP = 8'h6D;
  localparam logic [7:0] OPC_WAIT = 8'hED;
  // group masks
  localparam logic [2:0] REL_NZ = 3'h0;
  localparam logic [2:0] REL_NC = 3'h2;
  localparam logic [2:0] REL_Z = 3'h4;
  localparam logic [2:0] REL_C = 3'h6;
  localparam logic [2:0] REL_LOW = 3'h0;
  localparam logic [3:0] LO_CALL = 4'h1;
  localparam logic [3:0] LO_JP = 4'h9;
  localparam logic [3:0] LO_BT = 4'h3;
  localparam logic [3:0] LO_BM = 4'hB;
  localparam int IDX_XREG = 0;
  localparam int IDX_YREG = 1;
  localparam logic [7:0] ADR_XREG = 8'h80;
  localparam logic [7:0] ADR_YREG = 8'h81;
endpackage
`default_nettype wire

// >>> logic/acc_decode.sv
// opcode decoder: operation, length, cycle count and operand source
`timescale 1ns/1ps
`default_nettype none
module acc_decode
  import acc_pkg::*;
(
  // opcode
  input wire logic [7:0] opcode,
  // decoded
  output acc_op_type op,
  output acc_src_type src,
  output logic [1:0] len,
  output logic [2:0] cycles,
  output logic use_y
);
  always_comb
  begin
    op = OP_ILL;
    src = SRC_NONE;
    len = LEN_1;
    cycles = CYC_ALU;
    use_y = opcode[4];
    if (opcode[0] == REL_LOW[0] && opcode != OPC_NOP)
    begin
      // short relative: even opcodes other than OPC_NOP; test in bits 2:1, bit 3 backward, span 7:4
      cycles = CYC_REL;
      len = LEN_1;
      case ({opcode[2:1], 1'b0})
        REL_NZ: op = OP_BRNZ;
        REL_NC: op = OP_BRNC;
        REL_Z: op = OP_BRZ;
        REL_C: op = OP_BRC;
        default: op = OP_ILL;
      endcase
    end
    else if (opcode[3:0] == LO_CALL || opcode[3:0] == LO_JP)
    begin
      op = (opcode[3:0] == LO_CALL) ? OP_CALL : OP_JP;
      len = LEN_2;
      cycles = CYC_JMP;
    end
    else if (opcode[3:0] == LO_BT)
    begin
      op = opcode[4] ? OP_BTS : OP_BTR;
      len = LEN_3;
      cycles = CYC_BTB;
    end
    else if (opcode[3:0] == LO_BM)
    begin
      op = opcode[4] ? OP_BSET : OP_BCLR;
      len = LEN_2;
      cycles = CYC_BIT;
    end
    else
    begin
      // arithmetic/logic and control; indirect 1 byte, direct/imm 2 bytes, except OPC_CLRM with 3
      case (opcode)
        OPC_ADD_IX, OPC_ADD_IY: begin op = OP_ADD; src = SRC_MEM; end
        OPC_AND_IX, OPC_AND_IY: begin op = OP_AND; src = SRC_MEM; end
        OPC_CP_IX, OPC_CP_IY: begin op = OP_CMP; src = SRC_MEM; end
        OPC_SUB_IX, OPC_SUB_IY: begin op = OP_SUB; src = SRC_MEM; end
        OPC_INC_IX: op = OP_INC;
        OPC_DEC_IX: op = OP_DEC;
        OPC_ADD_D: begin op = OP_ADD; src = SRC_MEM; len = LEN_2; end
        OPC_AND_D: begin op = OP_AND; src = SRC_MEM; len = LEN_2; end
        OPC_CP_D: begin op = OP_CMP; src = SRC_MEM; len = LEN_2; end
        OPC_SUB_D: begin op = OP_SUB; src = SRC_MEM; len = LEN_2; end
        OPC_ADD_IMMEDIATE: begin op = OP_ADD; src = SRC_IMM; len = LEN_2; end
        OPC_AND_IMMEDIATE: begin op = OP_AND; src = SRC_IMM; len = LEN_2; end
        OPC_CPI: begin op = OP_CMP; src = SRC_IMM; len = LEN_2; end
        OPC_SUBTRACT_IMMEDIATE: begin op = OP_SUB; src = SRC_IMM; len = LEN_2; end
        OPC_INC_D: begin op = OP_INC; len = LEN_2; end
        OPC_DEC_D: begin op = OP_DEC; len = LEN_2; end
        OPC_CLRA: begin op = OP_CLRA; len = LEN_2; end
        OPC_CLRM: begin op = OP_CLRM; len = LEN_3; end
        OPC_COM: op = OP_COM;
        OPC_RLC: op = OP_RLC;
        OPC_SLA: begin op = OP_SLA; len = LEN_2; end
        OPC_NOP: begin op = OP_NOP; cycles = CYC_CTL; end
        OPC_RET: begin op = OP_RET; cycles = CYC_CTL; end
        OPC_INTERRUPT_RETURN: begin op = OP_INTERRUPT_RETURN; cycles = CYC_CTL; end
        OPC_STOP: begin op = OP_STOP; cycles = CYC_CTL; end
        OPC_WAIT: begin op = OP_WAIT; cycles = CYC_CTL; end
        default: op = OP_ILL;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> logic/acc_core.sv
// accumulator core: fetch, operand read, execute, write back
`timescale 1ns/1ps
`default_nettype none
module acc_core
  import acc_pkg::*;
#(
  parameter int PW = ACC_PW,
  parameter int STACK_DEPTH = ACC_SP_DEPTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // program memory
  output logic [PW-1:0] pm_addr,
  input wire logic [7:0] pm_data,
  // data space
  output logic [7:0] ds_addr,
  input wire logic [7:0] ds_rdata,
  output logic [7:0] ds_wdata,
  output logic ds_we,
  // options and status
  input wire logic watchdog_sel,
  input wire logic [1:0] irq_flags_z,
  output logic [7:0] acc_out,
  output logic zero_flag,
  output logic carry_flag,
  output logic stopped,
  output logic waiting
);
  typedef enum logic [2:0] {
    ST_FETCH = 3'h0, ST_BYTE2 = 3'h1, ST_BYTE3 = 3'h3, ST_EXEC = 3'h2, ST_HOLD = 3'h6
  } acc_state_type;

  acc_state_type state_r, state_nxt;
  logic [PW-1:0] pc_r, pc_nxt, ipc_r, ipc_nxt;
  logic [7:0] op_r, op_nxt, b2_r, b2_nxt, b3_r, b3_nxt, acc_r, acc_nxt;
  logic z_r, z_nxt, c_r, c_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic stop_r, stop_nxt, wait_r, wait_nxt;
  logic [PW-1:0] stk_r [STACK_DEPTH];
  logic [PW-1:0] stk_nxt [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH+1)-1:0] sp_r, sp_nxt;

  acc_op_type dop;
  acc_src_type dsrc;
  logic [1:0] dlen;
  logic [2:0] dcyc;
  logic duse_y;
  logic [8:0] sum;
  logic [7:0] opnd, ea, bitmask;
  logic take;
  logic fin;

  acc_decode u_dec (
    .opcode(op_r),
    .op(dop),
    .src(dsrc),
    .len(dlen),
    .cycles(dcyc),
    .use_y(duse_y)
  );

  assign pm_addr = pc_r;
  assign acc_out = acc_r;
  assign zero_flag = z_r;
  assign carry_flag = c_r;
  assign stopped = stop_r;
  assign waiting = wait_r;

  // effective data address: indirect through x/y, else second byte
  always_comb
  begin
    // x/y live in data space: the pointer byte is read in the second cycle
    if (state_r == ST_BYTE2 && dlen == LEN_1)
      ea = duse_y ? ADR_YREG : ADR_XREG;
    else
      ea = b2_r;
    opnd = (dsrc == SRC_IMM) ? b2_r : ds_rdata;
    bitmask = 8'h01 << op_r[7:5];
  end

  assign ds_addr = ea;

  // last cycle of the instruction; 2-cycle ops end right after fetch
  assign fin = (state_r == ST_EXEC || (state_r == ST_BYTE2 && dlen == LEN_1))
    && (cnt_r + 1'b1 >= dcyc);

  always_comb
  begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    ipc_nxt = ipc_r;
    op_nxt = op_r;
    b2_nxt = b2_r;
    b3_nxt = b3_r;
    acc_nxt = acc_r;
    z_nxt = z_r;
    c_nxt = c_r;
    cnt_nxt = cnt_r;
    stop_nxt = stop_r;
    wait_nxt = wait_r;
    sp_nxt = sp_r;
    stk_nxt = stk_r;
    ds_we = 1'b0;
    ds_wdata = 8'h00;
    sum = 9'h000;
    take = 1'b0;
    case (state_r)
      ST_FETCH:
      begin
        op_nxt = pm_data;
        ipc_nxt = pc_r;
        pc_nxt = pc_r + 1'b1;
        cnt_nxt = 3'h1;
        state_nxt = ST_BYTE2;
      end
      ST_BYTE2:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (dlen == LEN_1)
        begin
          // indirect forms keep the pointer byte as their address
          b2_nxt = ds_rdata;
          state_nxt = ST_EXEC;
        end
        else
        begin
          b2_nxt = pm_data;
          pc_nxt = pc_r + 1'b1;
          state_nxt = (dlen == LEN_3) ? ST_BYTE3 : ST_EXEC;
        end
      end
      ST_BYTE3:
      begin
        b3_nxt = pm_data;
        pc_nxt = pc_r + 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        state_nxt = ST_EXEC;
      end
      ST_EXEC:
      begin
        // pad to the cycle count; the work itself is done below
        cnt_nxt = cnt_r + 1'b1;
      end
      ST_HOLD:
      begin
        // left only by reset; wake-up lies outside this block
        state_nxt = ST_HOLD;
      end
      default: state_nxt = ST_FETCH;
    endcase
    // shared by the second-cycle and execute states
    if (fin)
    begin
      state_nxt = ST_FETCH;
      case (dop)
        OP_ADD:
        begin
          sum = {1'b0, acc_r} + {1'b0, opnd};
          acc_nxt = sum[7:0];
          z_nxt = (sum[7:0] == 8'h00);
          c_nxt = sum[8];
        end
        OP_SUB, OP_CMP:
        begin
          sum = {1'b0, acc_r} - {1'b0, opnd};
          if (dop == OP_SUB)
            acc_nxt = sum[7:0];
          z_nxt = (sum[7:0] == 8'h00);
          c_nxt = sum[8];
        end
        OP_AND:
        begin
          acc_nxt = acc_r & opnd;
          z_nxt = ((acc_r & opnd) == 8'h00);
          c_nxt = 1'b0;
        end
        OP_CLRA:
        begin
          acc_nxt = ACC_RESET;
          z_nxt = 1'b1;
          c_nxt = 1'b0;
        end
        OP_CLRM:
        begin
          ds_we = 1'b1; // flags untouched
          ds_wdata = 8'h00;
        end
        OP_COM:
        begin
          acc_nxt = ~acc_r;
          z_nxt = (acc_r == 8'hFF);
          c_nxt = acc_r[7];
        end
        OP_RLC, OP_SLA:
        begin
          acc_nxt = {acc_r[6:0], (dop == OP_RLC) ? c_r : 1'b0};
          z_nxt = ({acc_r[6:0], (dop == OP_RLC) ? c_r : 1'b0} == 8'h00);
          c_nxt = acc_r[7];
        end
        OP_INC, OP_DEC:
        begin
          sum = (dop == OP_INC) ? {1'b0, ds_rdata} + 9'h001 : {1'b0, ds_rdata} - 9'h001;
          ds_we = 1'b1;
          ds_wdata = sum[7:0];
          z_nxt = (sum[7:0] == 8'h00); // carry kept
        end
        OP_BRC, OP_BRNC, OP_BRZ, OP_BRNZ:
        begin
          case (dop)
            OP_BRC: take = c_r;
            OP_BRNC: take = ~c_r;
            OP_BRZ: take = z_r;
            default: take = ~z_r;
          endcase
          // 5-bit signed span around the branch address
          if (take)
            pc_nxt = op_r[3] ? ipc_r - PW'(op_r[7:4]) : ipc_r + PW'(op_r[7:4]) + 1'b1;
        end
        OP_BTR, OP_BTS:
        begin
          take = ((ds_rdata & bitmask) != 8'h00) == (dop == OP_BTS);
          c_nxt = (ds_rdata & bitmask) != 8'h00;
          if (take)
            pc_nxt = pc_r + PW'(signed'(b3_r));
        end
        OP_BSET, OP_BCLR:
        begin
          ds_we = 1'b1;
          ds_wdata = (dop == OP_BSET) ? (ds_rdata | bitmask) : (ds_rdata & ~bitmask);
        end
        OP_JP, OP_CALL:
        begin
          if (dop == OP_CALL && sp_r < STACK_DEPTH)
          begin
            stk_nxt[sp_r] = pc_r;
            sp_nxt = sp_r + 1'b1;
          end
          pc_nxt = {op_r[7:4], b2_r};
        end
        OP_RET, OP_INTERRUPT_RETURN:
        begin
          if (sp_r != '0)
          begin
            pc_nxt = stk_r[sp_r - 1'b1];
            sp_nxt = sp_r - 1'b1;
          end
          if (dop == OP_INTERRUPT_RETURN)
          begin
            z_nxt = irq_flags_z[0];
            c_nxt = irq_flags_z[1];
          end
        end
        OP_STOP, OP_WAIT:
        begin
          if (dop == OP_WAIT || watchdog_sel)
            wait_nxt = 1'b1;
          else
            stop_nxt = 1'b1;
          state_nxt = ST_HOLD;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_FETCH;
      pc_r <= PC_RESET;
      ipc_r <= PC_RESET;
      op_r <= OPC_NOP;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
      acc_r <= ACC_RESET;
      z_r <= 1'b0;
      c_r <= 1'b0;
      cnt_r <= 3'h0;
      stop_r <= 1'b0;
      wait_r <= 1'b0;
      sp_r <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stk_r[i] <= PC_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      ipc_r <= ipc_nxt;
      op_r <= op_nxt;
      b2_r <= b2_nxt;
      b3_r <= b3_nxt;
      acc_r <= acc_nxt;
      z_r <= z_nxt;
      c_r <= c_nxt;
      cnt_r <= cnt_nxt;
      stop_r <= stop_nxt;
      wait_r <= wait_nxt;
      sp_r <= sp_nxt;
      stk_r <= stk_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> verif/acc_mem.sv
// program and data memory model facing the core
`timescale 1ns/1ps
`default_nettype none
module acc_mem
  import acc_pkg::*;
#(
  parameter int PW = ACC_PW
)
(
  // clock
  input wire logic clk,
  // program side
  input wire logic [PW-1:0] pm_addr,
  output logic [7:0] pm_data,
  // data side
  input wire logic [7:0] ds_addr,
  output logic [7:0] ds_rdata,
  input wire logic [7:0] ds_wdata,
  input wire logic ds_we
);
  logic [7:0] pmem [0:(1<<PW)-1];
  logic [7:0] dmem [0:255];
  // reads are combinational: the core samples them in the same cycle
  assign pm_data = pmem[pm_addr];
  assign ds_rdata = dmem[ds_addr];
  // plain always so the bench may preload bytes
  always @(posedge clk)
  begin
    if (ds_we)
      dmem[ds_addr] <= ds_wdata;
  end
endmodule
`default_nettype wire

// >>> verif/acc_core_assertions.sv
// port checker for the accumulator core
`timescale 1ns/1ps
`default_nettype none
module acc_core_assertions
  import acc_pkg::*;
#(
  parameter int PW = ACC_PW
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // memories
  input wire logic [PW-1:0] pm_addr,
  input wire logic [7:0] pm_data,
  input wire logic [7:0] ds_addr,
  input wire logic [7:0] ds_rdata,
  input wire logic [7:0] ds_wdata,
  input wire logic ds_we,
  // options and status
  input wire logic watchdog_sel,
  input wire logic [1:0] irq_flags_z,
  input wire logic [7:0] acc_out,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic stopped,
  input wire logic waiting
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_halt;
    stopped || waiting;
  endsequence
  sequence s_wr;
    ds_we ##1 !ds_we;
  endsequence
  property p_rst;
    $rose(arst_n) |-> pm_addr == PC_RESET && acc_out == ACC_RESET
      && !zero_flag && !carry_flag;
  endproperty
  property p_we;
    ds_we |-> s_wr;
  endproperty
  property p_wec;
    ds_we |=> $stable(carry_flag);
  endproperty
  property p_wd;
    watchdog_sel |-> !$rose(stopped);
  endproperty
  property p_sth;
    stopped |=> stopped;
  endproperty
  property p_wth;
    waiting |=> waiting;
  endproperty
  property p_one;
    !(stopped && waiting);
  endproperty
  // a halted core must not retire anything
  property p_frz;
    s_halt |=> $stable(acc_out) && $stable(zero_flag) && $stable(carry_flag) && !ds_we;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_we: assert property (p_we) else $error("write strobe too long");
  a_wec: assert property (p_wec) else $error("carry moved on write");
  a_wd: assert property (p_wd) else $error("stop not turned to wait");
  a_sth: assert property (p_sth) else $error("stop state lost");
  a_wth: assert property (p_wth) else $error("wait state lost");
  a_one: assert property (p_one) else $error("stop and wait together");
  a_frz: assert property (p_frz) else $error("state moved while halted");
endmodule
bind acc_core acc_core_assertions #(.PW(PW)) i_chk (.clk(clk), .arst_n(arst_n),
  .pm_addr(pm_addr), .pm_data(pm_data), .ds_addr(ds_addr), .ds_rdata(ds_rdata),
  .ds_wdata(ds_wdata), .ds_we(ds_we), .watchdog_sel(watchdog_sel),
  .irq_flags_z(irq_flags_z), .acc_out(acc_out), .zero_flag(zero_flag),
  .carry_flag(carry_flag), .stopped(stopped), .waiting(waiting));
`default_nettype wire

// >>> verif/acc_core_tb.sv
// self-checking bench for the accumulator core
`timescale 1ns/1ps
`default_nettype none
module acc_core_tb
  import acc_pkg::*;
;
  logic clk, arst_n, ds_we, watchdog_sel, zero_flag, carry_flag, stopped, waiting;
  logic [11:0] pm_addr;
  logic [7:0] pm_data, ds_addr, ds_rdata, ds_wdata, acc_out;
  logic [1:0] irq_flags_z;
  int num_errors = 0;
  int n_checks = 0;
  int seed = 27623;
  int pc, m_acc, m_z, m_c, n_acc, n_z, n_c, k, f, a, v, t, r;
  int m_dmem [256];
  logic [7:0] opa [4][4] = '{'{OPC_ADD_IMMEDIATE, OPC_ADD_D, OPC_ADD_IX, OPC_ADD_IY},
    '{OPC_AND_IMMEDIATE, OPC_AND_D, OPC_AND_IX, OPC_AND_IY}, '{OPC_CPI, OPC_CP_D, OPC_CP_IX, OPC_CP_IY},
    '{OPC_SUBTRACT_IMMEDIATE, OPC_SUB_D, OPC_SUB_IX, OPC_SUB_IY}};
  logic [7:0] opu [4] = '{OPC_COM, OPC_RLC, OPC_SLA, OPC_CLRA};
  logic [7:0] opm [5] = '{OPC_INC_D, OPC_DEC_D, OPC_CLRM, {4'h1, LO_BM}, {4'h0, LO_BM}};
  acc_core i_dut (.clk(clk), .arst_n(arst_n), .pm_addr(pm_addr), .pm_data(pm_data),
    .ds_addr(ds_addr), .ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we),
    .watchdog_sel(watchdog_sel), .irq_flags_z(irq_flags_z), .acc_out(acc_out),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .stopped(stopped), .waiting(waiting));
  acc_mem i_mem (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .ds_addr(ds_addr),
    .ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic do_reset(input logic wd);
    arst_n = 1'b0;
    watchdog_sel = wd;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    pc = 0;
    m_acc = 0;
    m_z = 0;
    m_c = 0;
  endtask
  // next acc and flags; kinds 0..7 alu, 8 leaves all
  task automatic md(input int k, input int v);
    int s;
    s = (k == 0) ? m_acc + v : (k == 1) ? m_acc & v : (k < 4) ? m_acc - v
      : (k == 4) ? ~m_acc : (k == 5) ? m_acc * 2 + m_c : (k == 6) ? m_acc * 2 : 0;
    n_c = (k == 0) ? s > 255 : (k == 1 || k == 7) ? 0 : (k < 4) ? m_acc < v
      : (k < 7) ? m_acc / 128 : m_c;
    n_acc = (k == 2 || k > 7) ? m_acc : s & 255;
    n_z = (k > 7) ? m_z : (s & 255) == 0;
  endtask
  // places the bytes just ahead of the fetch, then checks timing and result
  task automatic ex(input int b0, b1, b2, len, cyc, tgt);
    int bs [3];
    bs = '{b0, b1, b2};
    for (int i = 0; i < len; i++) i_mem.pmem[(pc + i) % 4096] = 8'(bs[i]);
    pc = (tgt >= 0) ? tgt : (pc + len) % 4096;
    repeat (cyc - 1) @(negedge clk);
    chk("early", 12'(m_acc * 4 + m_z * 2 + m_c), {2'h0, acc_out, zero_flag, carry_flag});
    @(negedge clk);
    chk("acc flags", 12'(n_acc * 4 + n_z * 2 + n_c), {2'h0, acc_out, zero_flag, carry_flag});
    chk("next fetch", 12'(pc), pm_addr);
    m_acc = n_acc;
    m_z = n_z;
    m_c = n_c;
  endtask
  initial
  begin
    arst_n = 1'b0;
    watchdog_sel = 1'b0;
    irq_flags_z = 2'h0;
    for (int i = 0; i < 256; i++) m_dmem[i] = $random(seed) & 255;
    for (int i = 0; i < 256; i++) i_mem.dmem[i] = 8'(m_dmem[i]);
    do_reset(1'b0);
    for (int i = 0; i < 48; i++)
    begin
      k = $random(seed) & 7;
      f = $random(seed) & 3;
      a = $random(seed) & 255;
      v = (f == 0) ? a : (f == 1) ? m_dmem[a] : m_dmem[m_dmem[126 + f]];
      md(k, v);
      if (k < 4) ex(opa[k][f], a, 0, (f < 2) ? 2 : 1, 4, -1);
      else ex(opu[k - 4], 255, 0, (k < 6) ? 1 : 2, 4, -1);
    end
    $display("alu test done");
    for (int i = 0; i < 256; i++)
    begin
      k = i % 5;
      t = (i / 5) % 8;
      md(8, 0);
      v = (k == 0) ? m_dmem[i] + 1 : (k == 1) ? m_dmem[i] - 1 : (k == 2) ? 0
        : (k == 3) ? m_dmem[i] | (1 << t) : m_dmem[i] & ~(1 << t);
      v = v & 255;
      if (k < 2) n_z = (v == 0);
      m_dmem[i] = v;
      ex(opm[k] | ((k > 2) ? t * 32 : 0), i, 0, (k == 2) ? 3 : 2, 4, -1);
      chk("data byte", 12'(v), {4'h0, i_mem.dmem[i]});
    end
    $display("data test done");
    for (int i = 0; i < 16; i++)
    begin
      a = $random(seed) & 255;
      v = $random(seed) & 255;
      t = i % 8;
      md(8, 0);
      n_c = (m_dmem[a] >> t) & 1;
      r = (pc + 3 + ((n_c == i / 8) ? (v ^ 128) - 128 : 0)) & 4095;
      ex(t * 32 + (i / 8) * 16 + LO_BT, a, v, 3, 5, r);
    end
    $display("bit branch test done");
    for (int i = 0; i < 16; i++)
    begin
      v = (i & 4) ? m_acc : $random(seed) & 255;
      md(2, v);
      ex(OPC_CPI, v, 0, 2, 4, -1);
      t = $random(seed) & 15;
      f = i % 4;
      k = (i / 8) % 2;
      a = (f == 0) ? !m_z : (f == 1) ? !m_c : (f == 2) ? m_z : m_c;
      md(8, 0);
      r = !a ? pc + 1 : k ? pc - t : pc + t + 1;
      ex(t * 16 + k * 8 + f * 2, 0, 0, 1, 2, r & 4095);
    end
    $display("short branch test done");
    for (int i = 0; i < 4; i++)
    begin
      t = 2048 + ($random(seed) & 1023);
      md(8, 0);
      ex((t / 256) * 16 + LO_JP, t & 255, 0, 2, 4, t);
      t = 2048 + ($random(seed) & 1023);
      r = (pc + 2) % 4096;
      ex((t / 256) * 16 + LO_CALL, t & 255, 0, 2, 4, t);
      ex(OPC_NOP, 0, 0, 1, 2, -1);
      irq_flags_z = 2'($random(seed));
      n_z = i[0] ? irq_flags_z[0] : m_z;
      n_c = i[0] ? irq_flags_z[1] : m_c;
      ex(i[0] ? OPC_INTERRUPT_RETURN : OPC_RET, 0, 0, 1, 2, r);
    end
    $display("jump test done");
    for (int i = 0; i < 3; i++)
    begin
      do_reset(i == 0);
      md(8, 0);
      ex(i == 2 ? OPC_WAIT : OPC_STOP, 0, 0, 1, 2, -1);
      repeat (3) @(negedge clk);
      chk("halt", 12'((i == 1) * 2 + (i != 1)), {10'h0, stopped, waiting});
    end
    $display("halt test done");
    summarize();
  end
  // tests need under 2000 cycles; this leaves a wide margin
  initial
  begin
    #80000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
